// File: include/pps_params.svh
/*
  Constants of the poison and error status block: register offsets, field
  positions and reset values. Assumes inclusion by bare name.
*/
// Function
// RULE1: Poisoned received packets still go to application
// RULE2: Poisoned configuration writes leave registers unchanged
// RULE3: Locally made completions never carry poison_flag
// RULE4: Any poisoned receive sets detected parity
// RULE5: Parity enable plus poisoned write sends master parity
// RULE6: Parity enable plus poisoned completion sets master parity
// RULE7: Transmit packets pass through unchanged, never dropped
// RULE8: Error status resets zero, sticks once set
// RULE9: Writing one clears status, zero keeps it
// RULE10: Poisoned receive logs uncorrectable non-fatal error
// RULE11: Parity enable is command bit 6, resets 0
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH
`define PPS_ADDR_W 8
`define PPS_OFF_CMDSTAT 8'h00
`define PPS_OFF_UNCOR 8'h04
`define PPS_OFF_CORR 8'h08
`define PPS_OFF_IRQSTAT 8'h0c
`define PPS_OFF_IRQMASK 8'h10
`define PPS_CMD_PAR_EN 6
`define PPS_STAT_MDPE 8
`define PPS_STAT_DPE 15
`define PPS_UNCOR_POISON 12
`define PPS_CMD_RST 16'h0000
`define PPS_ERR_RST 32'h0000_0000
`define PPS_IRQ_W 3
`define PPS_IRQ_POISON 0
`define PPS_IRQ_MDPE 1
`define PPS_IRQ_CORR 2
`endif

// File: include/pps_pkg.sv
/*
  Types of the poison and error status block: packet kinds and state record.
  Assumes pps_params.svh is on the include path.
*/
`default_nettype none
`include "pps_params.svh"
package pps_pkg;
  // Packet kinds seen on both streams
  typedef enum logic [1:0] {PPS_MEMWR, PPS_CFGWR, PPS_CPL, PPS_OTHER} pps_kind_e;

  typedef struct packed {
    logic [15:0] cmd;
    logic dpe;
    logic mdpe;
    logic [31:0] uncor;
    logic [31:0] corr;
    logic [`PPS_IRQ_W-1:0] irq_stat;
    logic [`PPS_IRQ_W-1:0] irq_mask;
    logic irq;
    logic rxo_valid;
    pps_kind_e rxo_kind;
    logic rxo_poison;
    logic [31:0] rxo_data;
    logic txo_valid;
    pps_kind_e txo_kind;
    logic txo_poison;
    logic [31:0] txo_data;
    logic cpl_valid;
    logic cpl_poison;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pps_state_s;
endpackage
`default_nettype wire

// File: src/pps_top.sv
/*
  Poison handling and error status logging for the transaction layer.
  Assumes one clock, APB master for software, link-side and application-side
  packet strobes synchronous to pclk, one packet per cycle at most.
*/
// The address map and the APB slave port were left to the implementer.
`default_nettype none
`include "pps_params.svh"
module pps_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PPS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire pps_pkg::pps_kind_e rx_kind,
  input wire logic rx_poison,
  input wire logic [31:0] rx_data,
  output logic app_rx_valid,
  output pps_pkg::pps_kind_e app_rx_kind,
  output logic app_rx_poison,
  output logic [31:0] app_rx_data,
  input wire logic app_tx_valid,
  input wire pps_pkg::pps_kind_e app_tx_kind,
  input wire logic app_tx_poison,
  input wire logic [31:0] app_tx_data,
  output logic link_tx_valid,
  output pps_pkg::pps_kind_e link_tx_kind,
  output logic link_tx_poison,
  output logic [31:0] link_tx_data,
  output logic cfg_cpl_valid,
  output logic cfg_cpl_poison,
  input wire logic [31:0] uncor_evt,
  input wire logic [31:0] corr_evt,
  output logic irq
);
  import pps_pkg::*;

  pps_state_s st;
  pps_state_s next_st;

  logic setup;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic mapped;
  logic rx_poisoned;
  logic cfg_wr_ok;
  logic mdpe_evt;
  logic [31:0] uncor_set;
  logic [31:0] corr_set;
  logic [`PPS_IRQ_W-1:0] irq_set;

  // Bus phases; effects happen only at the access edge with pready high
  assign setup = psel && !penable;
  assign acc = psel && penable && st.pready;
  assign wr_go = acc && pwrite;
  assign rd_go = acc && !pwrite;
  assign mapped = (paddr == `PPS_OFF_CMDSTAT) || (paddr == `PPS_OFF_UNCOR) ||
                  (paddr == `PPS_OFF_CORR) || (paddr == `PPS_OFF_IRQSTAT) ||
                  (paddr == `PPS_OFF_IRQMASK);

  // Packet-driven events
  assign rx_poisoned = rx_valid && rx_poison;
  assign cfg_wr_ok = rx_valid && (rx_kind == PPS_CFGWR) && !rx_poison; // RULE2
  assign mdpe_evt = st.cmd[`PPS_CMD_PAR_EN] && // RULE11
                    ((app_tx_valid && app_tx_poison && (app_tx_kind == PPS_MEMWR)) || // RULE5
                     (rx_poisoned && (rx_kind == PPS_CPL))); // RULE6
  assign uncor_set = uncor_evt | (rx_poisoned ? (32'h0000_0001 << `PPS_UNCOR_POISON)
                                              : 32'h0000_0000); // RULE10
  assign corr_set = corr_evt;
  assign irq_set = {(|corr_evt), mdpe_evt, rx_poisoned};

  // Whole next state; event sets are ORed after clears so a set wins
  always_comb begin
    logic [31:0] w1c;
    logic [`PPS_IRQ_W-1:0] rd_clr;
    w1c = 32'h0000_0000;
    rd_clr = '0;
    next_st = st;
    next_st.pready = setup;
    if (setup) begin
      next_st.pslverr = !mapped;
      case (paddr)
        `PPS_OFF_CMDSTAT: next_st.prdata = {st.dpe, 6'h00, st.mdpe, 8'h00, st.cmd};
        `PPS_OFF_UNCOR: next_st.prdata = st.uncor;
        `PPS_OFF_CORR: next_st.prdata = st.corr;
        `PPS_OFF_IRQSTAT: next_st.prdata = {29'h0000_0000, st.irq_stat};
        `PPS_OFF_IRQMASK: next_st.prdata = {29'h0000_0000, st.irq_mask};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_go) begin
      w1c = pwdata; // RULE9
    end
    // Command register and parity status bits
    if (wr_go && paddr == `PPS_OFF_CMDSTAT) begin
      next_st.cmd = pwdata[15:0];
    end
    if (cfg_wr_ok) begin
      next_st.cmd = rx_data[15:0]; // RULE2
    end
    next_st.dpe = st.dpe;
    next_st.mdpe = st.mdpe;
    if (wr_go && paddr == `PPS_OFF_CMDSTAT && w1c[16 + `PPS_STAT_DPE]) begin
      next_st.dpe = 1'b0;
    end
    if (wr_go && paddr == `PPS_OFF_CMDSTAT && w1c[16 + `PPS_STAT_MDPE]) begin
      next_st.mdpe = 1'b0;
    end
    next_st.dpe = next_st.dpe || rx_poisoned; // RULE4
    next_st.mdpe = next_st.mdpe || mdpe_evt;
    // Error logs: sticky until a one is written
    if (wr_go && paddr == `PPS_OFF_UNCOR) begin
      next_st.uncor = st.uncor & ~w1c; // RULE9
    end
    if (wr_go && paddr == `PPS_OFF_CORR) begin
      next_st.corr = st.corr & ~w1c;
    end
    next_st.uncor = next_st.uncor | uncor_set; // RULE8
    next_st.corr = next_st.corr | corr_set; // RULE8
    // Read clears only what the captured read data showed, so nothing is lost
    if (rd_go && paddr == `PPS_OFF_IRQSTAT) begin
      rd_clr = st.prdata[`PPS_IRQ_W-1:0];
    end
    next_st.irq_stat = (st.irq_stat & ~rd_clr) | irq_set;
    if (wr_go && paddr == `PPS_OFF_IRQMASK) begin
      next_st.irq_mask = pwdata[`PPS_IRQ_W-1:0];
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
    // Receive path: every packet reaches the application, poisoned or not
    next_st.rxo_valid = rx_valid; // RULE1
    next_st.rxo_kind = rx_kind;
    next_st.rxo_poison = rx_poison;
    next_st.rxo_data = rx_data;
    // Transmit path: copied as is, no gating on poison
    next_st.txo_valid = app_tx_valid; // RULE7
    next_st.txo_kind = app_tx_kind;
    next_st.txo_poison = app_tx_poison;
    next_st.txo_data = app_tx_data;
    // Completion for each configuration write; never poisoned
    next_st.cpl_valid = rx_valid && (rx_kind == PPS_CFGWR);
    next_st.cpl_poison = 1'b0; // RULE3
  end

  // Single state register; all-zero reset covers command and logs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0; // RULE11
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign app_rx_valid = st.rxo_valid;
  assign app_rx_kind = st.rxo_kind;
  assign app_rx_poison = st.rxo_poison;
  assign app_rx_data = st.rxo_data;
  assign link_tx_valid = st.txo_valid;
  assign link_tx_kind = st.txo_kind;
  assign link_tx_poison = st.txo_poison;
  assign link_tx_data = st.txo_data;
  assign cfg_cpl_valid = st.cpl_valid;
  assign cfg_cpl_poison = st.cpl_poison;
  assign irq = st.irq;

  // Helper terms for the checks below
  logic cmd_wr;
  logic uncor_wr;
  assign cmd_wr = wr_go && (paddr == `PPS_OFF_CMDSTAT);
  assign uncor_wr = wr_go && (paddr == `PPS_OFF_UNCOR);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);


  // Every received packet reaches the application one cycle later
  a_rx_forward: assert property (rx_valid |=> app_rx_valid && // RULE1
    app_rx_poison == $past(rx_poison) && app_rx_data == $past(rx_data))
    else $error("received packet not forwarded intact");

  // Poisoned configuration write must not touch the command word
  a_cfg_drop: assert property (rx_valid && rx_kind == PPS_CFGWR && rx_poison && !cmd_wr // RULE2
    |=> st.cmd == $past(st.cmd))
    else $error("poisoned configuration write changed command");

  // Clean configuration write loads its low half into the command word
  a_cmd_load: assert property (cfg_wr_ok |=> st.cmd == $past(rx_data[15:0])) // RULE2
    else $error("clean configuration write not loaded");

  // Locally made completions are never poisoned
  a_cpl_clean: assert property (cfg_cpl_valid |-> !cfg_cpl_poison) // RULE3
    else $error("completion sent poisoned");

  // Each configuration write is answered by a completion
  a_cpl_follow: assert property (rx_valid && rx_kind == PPS_CFGWR |=> cfg_cpl_valid) // RULE3
    else $error("configuration write got no completion");

  // Any poisoned receive raises detected parity
  a_dpe_set: assert property (rx_poisoned |=> st.dpe) // RULE4
    else $error("detected parity not set");

  // Poisoned memory write sent with parity enabled
  a_mdpe_tx: assert property (st.cmd[`PPS_CMD_PAR_EN] && app_tx_valid && app_tx_poison && // RULE5
    app_tx_kind == PPS_MEMWR |=> st.mdpe)
    else $error("master parity not set on poisoned write");

  // Poisoned completion received with parity enabled
  a_mdpe_cpl: assert property (st.cmd[`PPS_CMD_PAR_EN] && rx_poisoned && // RULE6
    rx_kind == PPS_CPL |=> st.mdpe)
    else $error("master parity not set on poisoned completion");

  // Without parity enable a clear master parity flag stays clear
  a_mdpe_gate: assert property (!st.cmd[`PPS_CMD_PAR_EN] && !st.mdpe |=> !st.mdpe) // RULE11
    else $error("master parity set while parity disabled");

  // Transmit stream is copied, never held back
  a_tx_pass: assert property (app_tx_valid |=> link_tx_valid && // RULE7
    link_tx_poison == $past(app_tx_poison) && link_tx_data == $past(app_tx_data))
    else $error("transmit packet altered or dropped");

  // Log bit holds until software writes it
  a_uncor_sticky: assert property ($past(st.uncor[`PPS_UNCOR_POISON]) && // RULE8
    !$past(uncor_wr) |-> st.uncor[`PPS_UNCOR_POISON])
    else $error("error log bit fell without clear");

  // Correctable events always land in the log
  a_corr_sticky: assert property (corr_evt != 32'h0000_0000 // RULE8
    |=> (st.corr & $past(corr_evt)) == $past(corr_evt))
    else $error("correctable event not logged");

  // Zero written leaves every log bit in place
  a_zero_keep: assert property (uncor_wr && pwdata == 32'h0000_0000 // RULE9
    |=> (st.uncor & $past(st.uncor)) == $past(st.uncor))
    else $error("writing zero cleared a log bit");

  // Poisoned receive is logged as uncorrectable
  a_poison_log: assert property (rx_poisoned |=> st.uncor[`PPS_UNCOR_POISON]) // RULE10
    else $error("poisoned receive not logged");

  // Unmasked event raises the line next cycle; a mask write may veto it
  a_irq_level: assert property ((irq_set & st.irq_mask) != '0 &&
    !(wr_go && paddr == `PPS_OFF_IRQMASK) |=> irq)
    else $error("interrupt level wrong");

  // Answer comes exactly one cycle after setup
  a_ready_setup: assert property (setup |=> pready)
    else $error("no ready after setup");

  // Ready is a single-cycle pulse
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");

  // Unmapped address answers with an error and zero data
  a_slverr_map: assert property (setup && !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Main scenarios worth seeing at least once
  c_poison_rx: cover property (rx_poisoned ##1 app_rx_poison);

  c_cfg_dropped: cover property (rx_valid && rx_kind == PPS_CFGWR && rx_poison);

  c_apb_clear: cover property (uncor_wr && pwdata != 32'h0000_0000);

  c_mdpe_tx: cover property (mdpe_evt && app_tx_valid);

  c_irq_rise: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// File: verification/pps_far.sv
/*
  Far-side model: link receive stream and application transmit stream.
  Assumes pclk from the bench and a caller that waits for each beat.
*/
`default_nettype none
module pps_far
  import pps_pkg::*;
(
  input wire logic pclk,
  output logic rx_valid,
  output pps_pkg::pps_kind_e rx_kind,
  output logic rx_poison,
  output logic [31:0] rx_data,
  output logic tx_valid,
  output pps_pkg::pps_kind_e tx_kind,
  output logic tx_poison,
  output logic [31:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet lines at time zero
  initial begin
    rx_valid = 1'b0;
    tx_valid = 1'b0;
    rx_poison = 1'b0;
    tx_poison = 1'b0;
    rx_kind = PPS_OTHER;
    tx_kind = PPS_OTHER;
    rx_data = 32'h0000_0000;
    tx_data = 32'h0000_0000;
  end
  // One beat; idle lines then show the inverse so stale data never matches
  task automatic beat(input logic tx, input pps_kind_e k, input logic p,
      input logic [31:0] d);
    @(posedge pclk);
    if (tx) begin
      tx_valid <= 1'b1;
      tx_kind <= k;
      tx_poison <= p;
      tx_data <= d;
    end else begin
      rx_valid <= 1'b1;
      rx_kind <= k;
      rx_poison <= p;
      rx_data <= d;
    end
    @(posedge pclk);
    if (tx) begin
      tx_valid <= 1'b0;
      tx_kind <= pps_kind_e'(~k);
      tx_poison <= ~p;
      tx_data <= ~d;
    end else begin
      rx_valid <= 1'b0;
      rx_kind <= pps_kind_e'(~k);
      rx_poison <= ~p;
      rx_data <= ~d;
    end
  endtask
endmodule
`default_nettype wire

// File: verification/pps_top_bench.sv
/*
  Self-checking bench: APB register tasks, stream beats through pps_far.
  Assumes the package and pps_params.svh are compiled first.
*/
`default_nettype none
module pps_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pps_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, arp;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, uncor_evt, corr_evt, rd_, ad, td, ltd;
  logic rv, rp, ap, tv, tp, lv, lp, cv, cp;
  pps_kind_e rk, ak, tk, lk;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  pps_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rv), .rx_kind(rk), .rx_poison(rp), .rx_data(rd_),
    .app_rx_valid(ap), .app_rx_kind(ak), .app_rx_poison(arp), .app_rx_data(ad),
    .app_tx_valid(tv), .app_tx_kind(tk), .app_tx_poison(tp), .app_tx_data(td),
    .link_tx_valid(lv), .link_tx_kind(lk), .link_tx_poison(lp), .link_tx_data(ltd),
    .cfg_cpl_valid(cv), .cfg_cpl_poison(cp), .uncor_evt(uncor_evt),
    .corr_evt(corr_evt), .irq(irq));
  pps_far i_far (.pclk(pclk), .rx_valid(rv), .rx_kind(rk), .rx_poison(rp),
    .rx_data(rd_), .tx_valid(tv), .tx_kind(tk), .tx_poison(tp), .tx_data(td));
  // Clock at 50 MHz
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard, far above the roughly 120 cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Setup then access, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", r, exp);
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {uncor_evt, corr_evt} = 64'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0);
    apb(1'b1, 8'h10, 32'h7);
    apb(1'b1, 8'h00, 32'h40);
    // Poisoned memory write still reaches the application
    i_far.beat(1'b0, PPS_MEMWR, 1'b1, 32'h1234_5678);
    #1 chk("app_rx", {ap, arp, ad[29:0]}, {2'h3, 30'h1234_5678});
    chk("app_rx_kind", 32'(ak), 32'(PPS_MEMWR));
    @(posedge pclk);
    #1 chk("irq", 32'(irq), 32'h1);
    rdc(8'h00, 32'h8000_0040);
    rdc(8'h04, 32'h0000_1000);
    apb(1'b1, 8'h00, 32'h0000_0040);
    rdc(8'h00, 32'h8000_0040);
    apb(1'b1, 8'h00, 32'h8000_0040);
    rdc(8'h00, 32'h0000_0040);
    // Poisoned configuration write: completion clean, command untouched
    i_far.beat(1'b0, PPS_CFGWR, 1'b1, 32'h0);
    #1 chk("cfg_cpl", {cv, cp}, 32'h2);
    rdc(8'h00, 32'h8000_0040);
    i_far.beat(1'b0, PPS_CPL, 1'b1, 32'h5);
    rdc(8'h00, 32'h8100_0040);
    apb(1'b1, 8'h00, 32'h8100_0040);
    i_far.beat(1'b1, PPS_MEMWR, 1'b1, 32'hdead_beef);
    #1 chk("link_tx", {lv, lp, ltd[29:0]}, {2'h3, 30'h1ead_beef});
    chk("link_tx_kind", 32'(lk), 32'(PPS_MEMWR));
    rdc(8'h00, 32'h0100_0040);
    // Clean configuration write clears parity enable; no report after
    i_far.beat(1'b0, PPS_CFGWR, 1'b0, 32'h0);
    rdc(8'h00, 32'h0100_0000);
    apb(1'b1, 8'h00, 32'h0100_0000);
    i_far.beat(1'b1, PPS_MEMWR, 1'b1, 32'h1);
    rdc(8'h00, 32'h0);
    rdc(8'h0c, 32'h3);
    rdc(8'h0c, 32'h0);
    #1 chk("irq", 32'(irq), 32'h0);
    @(posedge pclk);
    {uncor_evt, corr_evt} <= {32'h5, 32'h100};
    @(posedge pclk);
    {uncor_evt, corr_evt} <= 64'h0;
    rdc(8'h04, 32'h1005);
    apb(1'b1, 8'h04, 32'h1004);
    rdc(8'h04, 32'h1);
    rdc(8'h08, 32'h100);
    apb(1'b1, 8'h08, 32'h100);
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h4);
    apb(1'b1, 8'h14, 32'hffff_ffff);
    chk("pslverr", 32'(e), 32'h1);
    rdc(8'h14, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
